// ---- dv/pin_model.sv ----
/*
  Pin model: works out each port pin from the block's pull-down enables and an outside driver.
  Assumes a pull-up on every pin and outside drivers that the bench switches on and off.
*/
`timescale 1ns/1ps
`default_nettype none

module pin_model (
  input wire logic [19:0] i_oe_n,
  input wire logic [19:0] i_ext_en,
  input wire logic [19:0] i_ext_val,
  output logic [19:0] o_pin
);
  // A released pin rises only where no one pulls it low, so the device's pull-down always wins.
  always_comb begin
    o_pin = i_oe_n & (~i_ext_en | i_ext_val);
  end
endmodule : pin_model

`default_nettype wire

// ---- dv/tb_port_aux_mux_and_timing.sv ----
/*
  Testbench of the port block: register bus reads and writes, pin and alternate-function checks.
  Assumes the pin model supplies the pull-ups and the bench stands in for the core and the peripherals.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_port_aux_mux_and_timing;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rmw = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, p1_out, p1_oe_n, p3_out, p3_oe_n;
  logic [3:0] phase, p4_out, p4_oe_n;
  logic [19:0] pins, ext_en = 20'h00000, ext_val = 20'h00000;
  logic [7:0] pwm_level = 8'hFF, pwm_en = 8'h00;
  logic sync_mode = 1'b0, ser_out = 1'b1, txd = 1'b1, mem_act = 1'b0, wr_n = 1'b1, rd_n = 1'b1;
  logic t2c, t2a, rxd, ext_interrupt_zero_n, ext_interrupt_one_n, t0c, t1c;
  int err_count = 0;
  int n_tests = 0;

  always #4 clk = ~clk;

  pin_model pin_model_inst (.i_oe_n({p4_oe_n, p3_oe_n, p1_oe_n}), .i_ext_en(ext_en), .i_ext_val(ext_val),
    .o_pin(pins));

  port_aux_mux_and_timing port_aux_mux_and_timing_inst (
    .i_clk_sys(clk), .i_sys_rst(rst), .i_sfr_addr(addr), .i_sfr_wr(wr), .i_sfr_wdata(wdata),
    .i_sfr_rd(rd), .i_sfr_rmw(rmw), .o_sfr_rdata(rdata), .o_phase(phase),
    .i_p1_pin(pins[7:0]), .o_p1_out(p1_out), .o_p1_oe_n(p1_oe_n),
    .i_p3_pin(pins[15:8]), .o_p3_out(p3_out), .o_p3_oe_n(p3_oe_n),
    .i_p4_pin(pins[19:16]), .o_p4_out(p4_out), .o_p4_oe_n(p4_oe_n),
    .i_pwm_level(pwm_level), .i_pwm_en(pwm_en), .i_ser_sync_mode(sync_mode), .i_ser_data_out(ser_out),
    .i_ser_txd(txd), .i_ext_mem_active(mem_act), .i_ext_wr_n(wr_n), .i_ext_rd_n(rd_n),
    .o_timer_two_count_input(t2c), .o_timer_two_aux_input(t2a), .o_ser_rxd(rxd),
    .o_ext_interrupt_zero_n(ext_interrupt_zero_n), .o_ext_interrupt_one_n(ext_interrupt_one_n),
    .o_timer_zero_count_input(t0c), .o_timer_one_count_input(t1c));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk

  // Returns one nanosecond after the edge that made the phase equal p.
  task automatic wait_phase(input logic [3:0] p);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (phase !== p && n < 40);
    if (phase !== p) begin
      err_count++;
      $display("wrong value at %0t: phase wait ran out", $time);
      stop_test();
    end
  endtask : wait_phase

  // Two waits for phase eleven, at least one full machine cycle, cover the synchroniser, one sampling phase and the registered alternates.
  task automatic settle();
    wait_phase(4'hB);
    wait_phase(4'hB);
  endtask : settle

  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(posedge clk);
    #1;
    wr = 1'b0;
    // One idle edge keeps a following call from raising a strobe in the step that lowered it.
    @(posedge clk);
    #1;
  endtask : sfr_write

  task automatic rchk(input logic [7:0] a, input logic m, input logic [7:0] exp, input string msg);
    addr = a;
    rmw = m;
    rd = 1'b1;
    @(posedge clk);
    #1;
    rd = 1'b0;
    chk(rdata, exp, msg);
    @(posedge clk);
    #1;
  endtask : rchk

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    chk(p1_oe_n, 8'hFF, "port one released after reset");
    chk({4'h0, p4_oe_n}, 8'h0F, "port four released after reset");
    rchk(8'h90, 1'b1, 8'hFF, "port one latch after reset");
    rchk(8'hD8, 1'b1, 8'h0F, "port four latch after reset");
    rchk(8'h55, 1'b1, 8'h00, "unmapped read");
    $display("test reset done");

    wait_phase(4'h3);
    sfr_write(8'hD8, 8'hF5);
    rchk(8'hD8, 1'b1, 8'h0F, "latch before phase twelve");
    // The latch has just committed here, but the output stage waits for phase one.
    wait_phase(4'h1);
    chk({4'h0, p4_oe_n}, 8'h0F, "stage before phase one");
    wait_phase(4'h2);
    chk({4'h0, p4_oe_n}, 8'h05, "port four pins after phase one");
    rchk(8'hD8, 1'b1, 8'h05, "port four upper bits");
    $display("test write timing done");

    sfr_write(8'h90, 8'h0F);
    ext_en = 20'h10003;
    ext_val = 20'h00002;
    pwm_en = 8'h04;
    pwm_level = 8'h00;
    settle();
    rchk(8'h90, 1'b1, 8'h0F, "port one latch read");
    rchk(8'h90, 1'b0, 8'h0A, "port one pin read");
    rchk(8'hD8, 1'b1, 8'h05, "port four latch read");
    rchk(8'hD8, 1'b0, 8'h04, "port four pin read");
    chk({7'h00, t2c}, 8'h00, "timer two count input");
    chk({7'h00, t2a}, 8'h01, "timer two aux input");
    chk(p1_oe_n, 8'h0B, "pulse channel two pulls low");
    $display("test pin and latch reads done");

    ext_en = 20'h01400;
    ext_val = 20'h00000;
    pwm_en = 8'h00;
    sync_mode = 1'b1;
    ser_out = 1'b0;
    txd = 1'b0;
    mem_act = 1'b1;
    wr_n = 1'b0;
    settle();
    chk(p3_oe_n, 8'hBC, "serial and write strobe");
    chk({6'h00, ext_interrupt_one_n, ext_interrupt_zero_n}, 8'h02, "interrupt inputs");
    chk({5'h00, t1c, t0c, rxd}, 8'h04, "timer and receive inputs");
    ext_en = 20'h00000;
    sync_mode = 1'b0;
    txd = 1'b1;
    wr_n = 1'b1;
    rd_n = 1'b0;
    sfr_write(8'hB0, 8'hFB);
    settle();
    chk(p3_oe_n, 8'h7B, "read strobe with latch bit two clear");
    chk({6'h00, ext_interrupt_one_n, ext_interrupt_zero_n}, 8'h02, "interrupt gated by latch");
    rchk(8'hB0, 1'b0, 8'h7B, "port three pin read");
    rchk(8'hB0, 1'b1, 8'hFB, "port three latch read");
    chk(p1_out | p3_out | {4'h0, p4_out}, 8'h00, "pins only ever pulled low");
    $display("test port three alternates done");

    wait_phase(4'h3);
    sfr_write(8'hD8, 8'h03);
    sfr_write(8'hD8, 8'h0C);
    wait_phase(4'h2);
    chk({4'h0, p4_oe_n}, 8'h0C, "later write in the cycle wins");
    rchk(8'hD8, 1'b1, 8'h0C, "port four latch after two writes");
    wait_phase(4'hC);
    sfr_write(8'hD8, 8'h06);
    rchk(8'hD8, 1'b1, 8'h06, "write in phase twelve lands at once");
    chk({4'h0, p4_oe_n}, 8'h06, "stage follows in the next phase one");
    $display("test write ordering done");

    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    chk(p3_oe_n, 8'hFF, "port three released after second reset");
    rchk(8'hB0, 1'b1, 8'hFF, "port three latch after second reset");
    rchk(8'hD8, 1'b1, 8'h0F, "port four latch after second reset");
    $display("test second reset done");
    stop_test();
  end
endmodule : tb_port_aux_mux_and_timing

`default_nettype wire

// ---- verilog/phase_seq.sv ----
/*
  Machine-cycle sequencer: counts the phases T1 to T12 and wraps.
  Assumes the processor core takes its phase from the same output.
*/
`timescale 1ns/1ps
`default_nettype none
`include "port_aux_consts.svh"

module phase_seq (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  output logic [3:0] o_phase
);

  port_aux_pkg::seq_state_t q;
  port_aux_pkg::seq_state_t d;

  always_comb begin
    d = q;
    if (q.phase == `PA_PHASE_LAST) begin
      d.phase = `PA_PHASE_FIRST;
    end else begin
      d.phase = q.phase + `PA_PHASE_STEP;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      q.phase <= `PA_PHASE_FIRST;
    end else begin
      q <= d;
    end
  end

  assign o_phase = q.phase;

endmodule : phase_seq

`default_nettype wire

// ---- verilog/port_aux_consts.svh ----
/*
  Constants of the port auxiliary multiplexer: register addresses, reset values and machine-cycle phases.
  Assumes it is included by bare name from the two design files.
*/
`ifndef PORT_AUX_CONSTS_SVH
`define PORT_AUX_CONSTS_SVH

// ----------------------------------------------------------------
// Register addresses on the special function register bus
// ----------------------------------------------------------------
`define PA_ADDR_PORT_ONE 8'h90
`define PA_ADDR_PORT_THREE 8'hB0
`define PA_ADDR_PORT_FOUR 8'hD8

// ----------------------------------------------------------------
// Reset values and fixed read fields
// ----------------------------------------------------------------
`define PA_LATCH_RESET8 8'hFF
`define PA_LATCH_RESET4 4'hF
`define PA_READ_ZERO8 8'h00
`define PA_READ_ZERO4 4'h0
`define PA_ALT_IDLE8 8'hFF
`define PA_ALT1_IDLE 2'h3

// ----------------------------------------------------------------
// Phases of the twelve-phase machine cycle
// ----------------------------------------------------------------
`define PA_PHASE_FIRST 4'h1
`define PA_PHASE_OUT 4'h1
`define PA_PHASE_SAMPLE_A 4'h9
`define PA_PHASE_SAMPLE_B 4'hA
`define PA_PHASE_LAST 4'hC
`define PA_PHASE_STEP 4'h1

`endif

// ---- verilog/port_aux_mux_and_timing.sv ----
/*
  Quasi-bidirectional port logic for port one, port three and port four: latches, alternate-function
  sharing, latch and pin read paths, and phase timing of latch update, output stage and pin sampling.
  Assumes the core presents one register write per instruction during its final machine cycle, and
  that the board or bench supplies the pull-up on every released pin.
*/
// Notes on behaviour
// - Port one bits 0 and 1 carry the timer-two count and auxiliary inputs or pulse outputs 0 and 1, bits 2-7 pulses 2-7.
// - Port three bit 0 is serial receive data (bidirectional data in synchronous mode), bit 1 transmit data or shift clock.
// - Port three bits 2 and 3 are external interrupts and timer gates, bits 4 and 5 the timer zero and one count inputs.
// - Port three bits 6 and 7 carry the active-low write and read strobes during external memory accesses.
// - An alternate function drives or senses a port three pin only while its latch holds 1; a 0 forces the pin low.
// - Port four sits at register address 0D8H, bits 3-0 drive its four pins and bits 7-4 are unused.
// - Port four pins behave like the other quasi-bidirectional port pins but have no alternate function and are sampled in phase ten.
// - Read-modify-write instructions read the port latch, not the pins.
// - All other port reads return the levels sampled at the pins.
// - A modified latch takes its new value in phase twelve of the final machine cycle.
// - The output stage samples the latch only in phase one, so a new value reaches the pin one phase after the latch.
// - Pins are sampled in phase nine for port one and in phase ten for port three.
// - A latch 0 turns the pull-down on and drives the pin low; a 1 releases it so the pin can be an input.
// - After reset every latch bit holds 1.
`timescale 1ns/1ps
`default_nettype none
`include "port_aux_consts.svh"

module port_aux_mux_and_timing (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic i_sfr_rd,
  input wire logic i_sfr_rmw,
  output logic [7:0] o_sfr_rdata,
  output logic [3:0] o_phase,
  input wire logic [7:0] i_p1_pin,
  output logic [7:0] o_p1_out,
  output logic [7:0] o_p1_oe_n,
  input wire logic [7:0] i_p3_pin,
  output logic [7:0] o_p3_out,
  output logic [7:0] o_p3_oe_n,
  input wire logic [3:0] i_p4_pin,
  output logic [3:0] o_p4_out,
  output logic [3:0] o_p4_oe_n,
  input wire logic [7:0] i_pwm_level,
  input wire logic [7:0] i_pwm_en,
  input wire logic i_ser_sync_mode,
  input wire logic i_ser_data_out,
  input wire logic i_ser_txd,
  input wire logic i_ext_mem_active,
  input wire logic i_ext_wr_n,
  input wire logic i_ext_rd_n,
  output logic o_timer_two_count_input,
  output logic o_timer_two_aux_input,
  output logic o_ser_rxd,
  output logic o_ext_interrupt_zero_n,
  output logic o_ext_interrupt_one_n,
  output logic o_timer_zero_count_input,
  output logic o_timer_one_count_input
);

  port_aux_pkg::port_state_t q;
  port_aux_pkg::port_state_t d;
  logic [3:0] phase;
  port_aux_pkg::pend_t wr_sel;
  port_aux_pkg::pend_t commit_sel;
  logic [7:0] commit_data;
  logic [7:0] alt3_out;
  logic [7:0] p1_low;

  function automatic logic [7:0] read_sel(input logic rmw, input logic [7:0] latch, input logic [7:0] samp);
    read_sel = rmw ? latch : samp;
  endfunction : read_sel

  // ----------------------------------------------------------------
  // Shared machine-cycle sequencer
  // ----------------------------------------------------------------
  phase_seq u_phase_seq (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .o_phase(phase)
  );
  assign o_phase = phase;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.sync1_a = i_p1_pin;
    d.sync1_b = q.sync1_a;
    d.sync3_a = i_p3_pin;
    d.sync3_b = q.sync3_a;
    d.sync4_a = i_p4_pin;
    d.sync4_b = q.sync4_a;

    // Sampling once per machine cycle is why a level must outlast a full cycle.
    if (phase == `PA_PHASE_SAMPLE_A) begin
      d.samp1 = q.sync1_b;
    end
    if (phase == `PA_PHASE_SAMPLE_B) begin
      d.samp3 = q.sync3_b;
      d.samp4 = q.sync4_b;
    end

    case (i_sfr_addr)
      `PA_ADDR_PORT_ONE: wr_sel = port_aux_pkg::PEND_ONE;
      `PA_ADDR_PORT_THREE: wr_sel = port_aux_pkg::PEND_THREE;
      `PA_ADDR_PORT_FOUR: wr_sel = port_aux_pkg::PEND_FOUR;
      default: wr_sel = port_aux_pkg::PEND_NONE;
    endcase
    if (!i_sfr_wr) begin
      wr_sel = port_aux_pkg::PEND_NONE;
    end

    // A write earlier in the cycle waits; a write in phase twelve itself lands at once.
    commit_sel = (wr_sel != port_aux_pkg::PEND_NONE) ? wr_sel : q.pend;
    commit_data = (wr_sel != port_aux_pkg::PEND_NONE) ? i_sfr_wdata : q.pend_data;
    if (phase == `PA_PHASE_LAST) begin
      case (commit_sel)
        port_aux_pkg::PEND_ONE: d.latch1 = commit_data;
        port_aux_pkg::PEND_THREE: d.latch3 = commit_data;
        port_aux_pkg::PEND_FOUR: d.latch4 = commit_data[3:0];
        default: d.latch1 = q.latch1;
      endcase
      d.pend = port_aux_pkg::PEND_NONE;
    end else if (wr_sel != port_aux_pkg::PEND_NONE) begin
      d.pend = wr_sel;
      d.pend_data = i_sfr_wdata;
    end

    if (phase == `PA_PHASE_OUT) begin
      d.stage1 = q.latch1;
      d.stage3 = q.latch3;
      d.stage4 = q.latch4;
    end

    // Pulse outputs can only pull low; a pulse high releases the pin to the pull-up.
    p1_low = ~d.stage1 | (i_pwm_en & ~i_pwm_level);
    d.oe1_n = ~p1_low;

    alt3_out = `PA_ALT_IDLE8;
    alt3_out[0] = ~i_ser_sync_mode | i_ser_data_out;
    alt3_out[1] = i_ser_txd;
    alt3_out[6] = ~i_ext_mem_active | i_ext_wr_n;
    alt3_out[7] = ~i_ext_mem_active | i_ext_rd_n;
    d.oe3_n = d.stage3 & alt3_out;
    d.oe4_n = d.stage4;

    d.alt1 = q.sync1_b[1:0];
    d.alt3 = q.sync3_b & q.stage3;

    if (i_sfr_rd) begin
      case (i_sfr_addr)
        `PA_ADDR_PORT_ONE: d.rdata = read_sel(i_sfr_rmw, q.latch1, q.samp1);
        `PA_ADDR_PORT_THREE: d.rdata = read_sel(i_sfr_rmw, q.latch3, q.samp3);
        `PA_ADDR_PORT_FOUR: d.rdata = read_sel(i_sfr_rmw, {`PA_READ_ZERO4, q.latch4}, {`PA_READ_ZERO4, q.samp4});
        default: d.rdata = `PA_READ_ZERO8;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      q <= '0;
      q.latch1 <= `PA_LATCH_RESET8;
      q.latch3 <= `PA_LATCH_RESET8;
      q.latch4 <= `PA_LATCH_RESET4;
      q.stage1 <= `PA_LATCH_RESET8;
      q.stage3 <= `PA_LATCH_RESET8;
      q.stage4 <= `PA_LATCH_RESET4;
      q.oe1_n <= `PA_LATCH_RESET8;
      q.oe3_n <= `PA_LATCH_RESET8;
      q.oe4_n <= `PA_LATCH_RESET4;
      q.samp1 <= `PA_LATCH_RESET8;
      q.samp3 <= `PA_LATCH_RESET8;
      q.samp4 <= `PA_LATCH_RESET4;
      q.alt3 <= `PA_ALT_IDLE8;
      q.alt1 <= `PA_ALT1_IDLE;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Pins only ever drive low; the high level comes from the pull-up.
  assign o_p1_out = `PA_READ_ZERO8;
  assign o_p3_out = `PA_READ_ZERO8;
  assign o_p4_out = `PA_READ_ZERO4;
  assign o_p1_oe_n = q.oe1_n;
  assign o_p3_oe_n = q.oe3_n;
  assign o_p4_oe_n = q.oe4_n;
  assign o_sfr_rdata = q.rdata;
  assign o_timer_two_count_input = q.alt1[0];
  assign o_timer_two_aux_input = q.alt1[1];
  assign o_ser_rxd = q.alt3[0];
  assign o_ext_interrupt_zero_n = q.alt3[2];
  assign o_ext_interrupt_one_n = q.alt3[3];
  assign o_timer_zero_count_input = q.alt3[4];
  assign o_timer_one_count_input = q.alt3[5];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);

  sequence s_write_p4_last;
    i_sfr_wr && (i_sfr_addr == `PA_ADDR_PORT_FOUR) && (phase == `PA_PHASE_LAST);
  endsequence

  sequence s_read_p1_rmw;
    i_sfr_rd && i_sfr_rmw && (i_sfr_addr == `PA_ADDR_PORT_ONE);
  endsequence

  a_latch_phase_twelve: assert property ((q.latch1 != $past(q.latch1)) |-> ($past(phase) == `PA_PHASE_LAST))
    else $error("port one latch changed outside phase twelve");
  a_p4_write_lands: assert property (s_write_p4_last |=> (q.latch4 == $past(i_sfr_wdata[3:0])))
    else $error("port four write did not land");
  a_stage_phase_one: assert property ((q.stage3 != $past(q.stage3)) |-> ($past(phase) == `PA_PHASE_OUT))
    else $error("output stage moved outside phase one");
  a_sample_nine: assert property ((q.samp1 != $past(q.samp1)) |-> ($past(phase) == `PA_PHASE_SAMPLE_A))
    else $error("port one sampled outside phase nine");
  a_sample_ten: assert property ((q.samp3 != $past(q.samp3)) |-> ($past(phase) == `PA_PHASE_SAMPLE_B))
    else $error("port three sampled outside phase ten");
  a_zero_drives_low: assert property (1'b1 |-> ((~q.stage3 & o_p3_oe_n) == `PA_READ_ZERO8))
    else $error("port three latch zero but pin released");
  a_rmw_reads_latch: assert property (s_read_p1_rmw |=> (o_sfr_rdata == $past(q.latch1)))
    else $error("read-modify-write did not read latch");
  a_pin_read_samp: assert property ((i_sfr_rd && !i_sfr_rmw && (i_sfr_addr == `PA_ADDR_PORT_THREE))
                                    |=> (o_sfr_rdata == $past(q.samp3)))
    else $error("pin read did not return sampled level");
  a_p4_upper_zero: assert property ((i_sfr_rd && (i_sfr_addr == `PA_ADDR_PORT_FOUR))
                                    |=> (o_sfr_rdata[7:4] == `PA_READ_ZERO4))
    else $error("port four upper bits not zero");
  a_wr_strobe_out: assert property ((i_ext_mem_active && !i_ext_wr_n && q.stage3[6] && (phase != `PA_PHASE_OUT))
                                    |=> !o_p3_oe_n[6])
    else $error("write strobe not driven");

endmodule : port_aux_mux_and_timing

`default_nettype wire

// ---- verilog/port_aux_pkg.sv ----
/*
  Types of the port auxiliary multiplexer and its machine-cycle sequencer.
  Assumes the constants header is on the include path.
*/
`default_nettype none

package port_aux_pkg;

  typedef logic [3:0] phase_t;

  // Pending latch write, Gray coded so that one bit moves per step.
  typedef enum logic [1:0] {
    PEND_NONE = 2'b00,
    PEND_ONE = 2'b01,
    PEND_THREE = 2'b11,
    PEND_FOUR = 2'b10
  } pend_t;

  typedef struct packed {
    phase_t phase;
  } seq_state_t;

  typedef struct packed {
    logic [7:0] latch1;
    logic [7:0] latch3;
    logic [3:0] latch4;
    pend_t pend;
    logic [7:0] pend_data;
    logic [7:0] stage1;
    logic [7:0] stage3;
    logic [3:0] stage4;
    logic [7:0] sync1_a;
    logic [7:0] sync1_b;
    logic [7:0] sync3_a;
    logic [7:0] sync3_b;
    logic [3:0] sync4_a;
    logic [3:0] sync4_b;
    logic [7:0] samp1;
    logic [7:0] samp3;
    logic [3:0] samp4;
    logic [7:0] oe1_n;
    logic [7:0] oe3_n;
    logic [3:0] oe4_n;
    logic [1:0] alt1;
    logic [7:0] alt3;
    logic [7:0] rdata;
  } port_state_t;

endpackage : port_aux_pkg

`default_nettype wire
